// File: design/csc_pkg.sv
package csc_pkg;
  // bus timing
  localparam int CLK_PERIOD_NS = 25;
  // register indices, byte address is four times the index
  localparam logic [15:0] IDX_STATUS = 16'h303C;
  localparam logic [15:0] IDX_OSC = 16'h303E;
  localparam logic [15:0] IDX_CTRL = 16'h3040;
  localparam logic [15:0] IDX_IRQ_STATUS = 16'h3041;
  localparam logic [15:0] IDX_IRQ_MASK = 16'h3042;
  // status bit positions
  localparam int ST_LOST = 7;
  localparam int ST_LOCK = 6;
  localparam int ST_REF = 4;
  localparam int ST_MODE = 2;
  // oscillator control bit positions
  localparam int OS_EN = 7;
  localparam int OS_KEEP = 5;
  localparam int OS_SEL = 4;
  localparam int OS_RANGE = 2;
  localparam int OS_GAIN = 1;
  localparam int OS_READY = 0;
  // clock mode encodings
  localparam logic [1:0] MODE_FLL = 2'h0;
  localparam logic [1:0] MODE_INT = 2'h1;
  localparam logic [1:0] MODE_EXT = 2'h2;
  // interrupt bits
  localparam int IRQ_W = 3;
  localparam int IRQ_LOST = 0;
  localparam int IRQ_LOCKED = 1;
  localparam int IRQ_OSC = 2;
  // counts
  localparam logic [4:0] LOCK_SETTLE_CYCLES = 5'h10;
  localparam logic [10:0] OSC_INIT_EDGES = 11'h400;
  // values after reset
  localparam logic [7:0] OSC_RESET = 8'h00;
  localparam logic [1:0] MODE_RESET = 2'h0;
  // control register kept by software
  typedef struct packed {
    logic [7:0] trim;
    logic [2:0] ref_divider;
    logic [1:0] clock_mode_select;
    logic ref_source_select;
  } csc_ctrl_t;
  localparam csc_ctrl_t CTRL_RESET = 14'h0001;
  // oscillator settings
  typedef struct packed {
    logic oscillator_enable;
    logic oscillator_stop_keep;
    logic out_sel;
    logic range_high;
    logic high_gain_select;
  } csc_osc_t;
  // index to byte address
  function automatic logic [15:0] addr_of(input logic [15:0] idx);
    return {idx[13:0], 2'b00};
  endfunction
endpackage

// File: design/csc_sync.sv
`timescale 1ns/1ps
module csc_sync
  import csc_pkg::*;
#(
  parameter int W = 2
)
(
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // async levels in, filtered levels out
  input wire logic [W-1:0] async_in,
  output logic [W-1:0] sync_out
);
  // three stages; s1 feeds only s2
  logic [W-1:0] s1;
  logic [W-1:0] s2;
  logic [W-1:0] s3;
  logic [W-1:0] next_out;

  // take a change only once stages two and three agree
  always_comb
  begin
    next_out = ((s2 ~^ s3) & s3) | ((s2 ^ s3) & sync_out);
  end

  // register the chain
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      s1 <= '0;
      s2 <= '0;
      s3 <= '0;
      sync_out <= '0;
    end
    else
    begin
      s1 <= async_in;
      s2 <= s1;
      s3 <= s2;
      sync_out <= next_out;
    end
  end
endmodule

// File: design/csc_irq.sv
`timescale 1ns/1ps
module csc_irq
  import csc_pkg::*;
(
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // one-cycle events from the block
  input wire logic [IRQ_W-1:0] event_in,
  // software access
  input wire logic clear_we,
  input wire logic mask_we,
  input wire logic [IRQ_W-1:0] wdata,
  // state and request
  output logic [IRQ_W-1:0] status,
  output logic [IRQ_W-1:0] mask,
  output logic irq
);
  logic [IRQ_W-1:0] next_status;
  logic [IRQ_W-1:0] next_mask;

  // write one clears, but a new event wins
  always_comb
  begin
    next_status = status;
    if (clear_we)
      next_status = status & ~wdata;
    next_status = next_status | event_in;
    next_mask = mask_we ? wdata : mask;
  end

  // register status and mask
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      status <= '0;
      mask <= '0;
    end
    else
    begin
      status <= next_status;
      mask <= next_mask;
    end
  end

  // level request while any unmasked bit is set
  assign irq = |(status & mask);
endmodule

// File: design/csc_top.sv
`timescale 1ns/1ps
module csc_top
  import csc_pkg::*;
(
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [15:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // system and analog side
  input wire logic stop_mode,
  input wire logic fll_locked_pin,
  input wire logic ext_clock_pin,
  // controls to the clock unit
  output csc_ctrl_t ctrl,
  output csc_osc_t osc,
  output logic osc_run,
  output logic external_ref_clock_out,
  // interrupt
  output logic irq
);
  // synchronised pin levels
  logic [1:0] pins_sync;
  logic locked_in;
  logic ext_level;
  // bus decode
  logic setup;
  logic access;
  logic wr;
  logic hit;
  logic next_hit;
  logic [31:0] next_prdata;
  logic we_status;
  logic we_osc;
  logic we_ctrl;
  logic we_irqs;
  logic we_irqm;
  // control state
  csc_ctrl_t next_ctrl;
  csc_osc_t next_osc;
  logic cfg_change;
  // status pipelines, two stages as a domain crossing
  logic ref_stage;
  logic ref_source_status;
  logic [1:0] mode_stage;
  logic [1:0] clock_mode_status;
  // lock tracking
  logic stop_d;
  logic lock_flag;
  logic next_lock_flag;
  logic [4:0] settle_cnt;
  logic [4:0] next_settle_cnt;
  logic lost_lock_sticky;
  logic next_sticky;
  logic lost_event;
  // oscillator
  logic next_osc_run;
  logic ext_d;
  logic [10:0] init_cnt;
  logic [10:0] next_init_cnt;
  logic oscillator_ready_flag;
  logic next_ready;
  logic next_erclk;
  logic osc_request;
  // interrupt block
  logic [IRQ_W-1:0] irq_events;
  logic [IRQ_W-1:0] irq_status;
  logic [IRQ_W-1:0] irq_mask;

  // fll lock and external clock come from other domains
  csc_sync #(.W(2)) u_sync (
    .pclk(pclk),
    .presetn(presetn),
    .async_in({ext_clock_pin, fll_locked_pin}),
    .sync_out(pins_sync)
  );
  assign locked_in = pins_sync[0];
  assign ext_level = pins_sync[1];

  // zero wait state slave
  assign pready = 1'b1;
  assign setup = psel & ~penable;
  assign access = psel & penable;
  assign wr = access & pwrite;
  assign pslverr = access & ~hit;
  assign we_status = wr & hit & (paddr == addr_of(IDX_STATUS));
  assign we_osc = wr & hit & (paddr == addr_of(IDX_OSC));
  assign we_ctrl = wr & hit & (paddr == addr_of(IDX_CTRL));
  assign we_irqs = wr & hit & (paddr == addr_of(IDX_IRQ_STATUS));
  assign we_irqm = wr & hit & (paddr == addr_of(IDX_IRQ_MASK));

  // read data captured in the setup cycle
  always_comb
  begin
    next_prdata = prdata;
    next_hit = hit;
    if (setup)
    begin
      next_hit = 1'b1;
      next_prdata = 32'h0000_0000;
      if (paddr == addr_of(IDX_STATUS))
      begin
        // bits 5 and 1..0 stay zero
        next_prdata[ST_LOST] = lost_lock_sticky;
        next_prdata[ST_LOCK] = lock_flag;
        next_prdata[ST_REF] = ref_source_status;
        next_prdata[ST_MODE+:2] = clock_mode_status;
      end
      else if (paddr == addr_of(IDX_OSC))
      begin
        // bits 6 and 3 stay zero
        next_prdata[OS_EN] = osc.oscillator_enable;
        next_prdata[OS_KEEP] = osc.oscillator_stop_keep;
        next_prdata[OS_SEL] = osc.out_sel;
        next_prdata[OS_RANGE] = osc.range_high;
        next_prdata[OS_GAIN] = osc.high_gain_select;
        next_prdata[OS_READY] = oscillator_ready_flag;
      end
      else if (paddr == addr_of(IDX_CTRL))
        next_prdata[13:0] = ctrl;
      else if (paddr == addr_of(IDX_IRQ_STATUS))
        next_prdata[IRQ_W-1:0] = irq_status;
      else if (paddr == addr_of(IDX_IRQ_MASK))
        next_prdata[IRQ_W-1:0] = irq_mask;
      else
        next_hit = 1'b0;
    end
  end

  // register bus read side
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      prdata <= 32'h0000_0000;
      hit <= 1'b0;
    end
    else
    begin
      prdata <= next_prdata;
      hit <= next_hit;
    end
  end

  // software controls
  always_comb
  begin
    next_ctrl = ctrl;
    next_osc = osc;
    cfg_change = 1'b0;
    if (we_ctrl)
    begin
      next_ctrl = csc_ctrl_t'(pwdata[13:0]);
      // trim only matters with the internal reference
      cfg_change = (next_ctrl.ref_source_select != ctrl.ref_source_select)
        | (next_ctrl.ref_divider != ctrl.ref_divider)
        | (ctrl.ref_source_select & (next_ctrl.trim != ctrl.trim));
    end
    if (we_osc)
    begin
      next_osc.oscillator_enable = pwdata[OS_EN];
      next_osc.oscillator_stop_keep = pwdata[OS_KEEP];
      next_osc.out_sel = pwdata[OS_SEL];
      next_osc.range_high = pwdata[OS_RANGE];
      next_osc.high_gain_select = pwdata[OS_GAIN];
    end
  end

  // register controls and status pipelines
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      ctrl <= CTRL_RESET;
      osc <= csc_osc_t'({OSC_RESET[OS_EN], OSC_RESET[OS_KEEP:OS_SEL],
        OSC_RESET[OS_RANGE:OS_GAIN]});
      ref_stage <= CTRL_RESET.ref_source_select;
      ref_source_status <= CTRL_RESET.ref_source_select;
      mode_stage <= MODE_RESET;
      clock_mode_status <= MODE_RESET;
    end
    else
    begin
      ctrl <= next_ctrl;
      osc <= next_osc;
      // status trails the select by two edges
      ref_stage <= ctrl.ref_source_select;
      ref_source_status <= ref_stage;
      mode_stage <= ctrl.clock_mode_select;
      clock_mode_status <= mode_stage;
    end
  end

  // lock flag needs a settled lock after any upset
  always_comb
  begin
    next_settle_cnt = settle_cnt;
    next_lock_flag = lock_flag;
    lost_event = lock_flag & ~locked_in;
    if (stop_mode | cfg_change | ~locked_in)
    begin
      // stop or a reference change forces relock
      next_settle_cnt = 5'h00;
      next_lock_flag = 1'b0;
    end
    else if (settle_cnt != LOCK_SETTLE_CYCLES)
      next_settle_cnt = settle_cnt + 5'h01;
    else
      next_lock_flag = 1'b1;
    // the set wins over the clear
    next_sticky = lost_lock_sticky;
    if (we_status & pwdata[ST_LOST])
      next_sticky = 1'b0;
    if (lost_event)
      next_sticky = 1'b1;
  end

  // register lock state
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      settle_cnt <= 5'h00;
      lock_flag <= 1'b0;
      lost_lock_sticky <= 1'b0;
      stop_d <= 1'b0;
    end
    else
    begin
      settle_cnt <= next_settle_cnt;
      lock_flag <= next_lock_flag;
      lost_lock_sticky <= next_sticky;
      stop_d <= stop_mode;
    end
  end

  // oscillator run, init count and reference output
  always_comb
  begin
    osc_request = ~ctrl.ref_source_select | (ctrl.clock_mode_select == MODE_EXT);
    if (stop_mode)
      next_osc_run = osc.oscillator_stop_keep
        & (osc.oscillator_enable | osc_request);
    else
      next_osc_run = osc.oscillator_enable | osc_request;
    next_init_cnt = init_cnt;
    next_ready = oscillator_ready_flag;
    if (!osc_run)
    begin
      // a restart is reported afresh
      next_init_cnt = 11'h000;
      next_ready = 1'b0;
    end
    else if (init_cnt == OSC_INIT_EDGES)
      next_ready = 1'b1;
    else if (ext_level & ~ext_d)
      next_init_cnt = init_cnt + 11'h001;
    // only a running, enabled oscillator drives the output
    next_erclk = osc.oscillator_enable & osc_run & ext_level;
  end

  // register oscillator state
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      osc_run <= 1'b0;
      init_cnt <= 11'h000;
      oscillator_ready_flag <= 1'b0;
      ext_d <= 1'b0;
      external_ref_clock_out <= 1'b0;
    end
    else
    begin
      osc_run <= next_osc_run;
      init_cnt <= next_init_cnt;
      oscillator_ready_flag <= next_ready;
      ext_d <= ext_level;
      external_ref_clock_out <= next_erclk;
    end
  end

  // events for the interrupt status
  assign irq_events[IRQ_LOST] = lost_event;
  assign irq_events[IRQ_LOCKED] = next_lock_flag & ~lock_flag;
  assign irq_events[IRQ_OSC] = next_ready & ~oscillator_ready_flag;

  csc_irq u_irq (
    .pclk(pclk),
    .presetn(presetn),
    .event_in(irq_events),
    .clear_we(we_irqs),
    .mask_we(we_irqm),
    .wdata(pwdata[IRQ_W-1:0]),
    .status(irq_status),
    .mask(irq_mask),
    .irq(irq)
  );

  // checks
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  sequence s_stop_entry;
    stop_mode && !stop_d;
  endsequence

  sequence s_stays_clear;
    !lock_flag [*2];
  endsequence

  AST_LOCK_STOP: assert property (s_stop_entry |=> s_stays_clear)
    else $error("lock flag set after stop entry");
  AST_LOCK_LEVEL: assert property (lock_flag |-> $past(locked_in))
    else $error("lock flag set while fll unlocked");
  AST_RSVD: assert property (access && paddr == addr_of(IDX_OSC)
    |-> prdata[6] == 1'b0 && prdata[3] == 1'b0)
    else $error("reserved oscillator bit reads one");
  AST_REF_LAG: assert property (ref_source_status == $past(ctrl.ref_source_select, 2))
    else $error("reference status does not trail select");
  AST_MODE_LAG: assert property (clock_mode_status == $past(ctrl.clock_mode_select, 2))
    else $error("mode status does not trail select");
  AST_OSC_STOP: assert property (stop_mode && !osc.oscillator_stop_keep |=> !osc_run)
    else $error("oscillator runs in stop without keep");
  AST_READY_OFF: assert property (!osc_run |=> !oscillator_ready_flag)
    else $error("ready flag set while oscillator stopped");
  AST_CFG_CLEAR: assert property (cfg_change |=> !lock_flag ##1 !lock_flag)
    else $error("lock flag survives reference change");
  AST_STICKY: assert property (lost_event |=> lost_lock_sticky)
    else $error("loss of lock not recorded");
  AST_W0: assert property (we_status && !pwdata[ST_LOST] && lost_lock_sticky
    |=> lost_lock_sticky)
    else $error("writing zero cleared the sticky flag");
endmodule

// File: testbench/csc_osc_model.sv
`timescale 1ns/1ps
module csc_osc_model
  import csc_pkg::*;
(
  // run request from the block
  input wire logic osc_run,
  // crystal swing onto the pin
  output logic ext_clock_pin
);
  // half period unrelated to pclk, slow enough for the pin synchroniser
  localparam time HALF_NS = 61;
  // a stopped crystal stands still low, it does not keep swinging
  initial ext_clock_pin = 1'b0;
  always #HALF_NS ext_clock_pin = osc_run ? ~ext_clock_pin : 1'b0;
endmodule

// File: testbench/clock_status_and_osc_control_tb.sv
`timescale 1ns/1ps
module clock_status_and_osc_control_tb
  import csc_pkg::*;
();
  // byte addresses, four times the index
  localparam logic [15:0] A_ST = {IDX_STATUS[13:0], 2'b00};
  localparam logic [15:0] A_OSC = {IDX_OSC[13:0], 2'b00};
  localparam logic [15:0] A_CT = {IDX_CTRL[13:0], 2'b00};
  localparam logic [15:0] A_IS = {IDX_IRQ_STATUS[13:0], 2'b00};
  localparam logic [15:0] A_IM = {IDX_IRQ_MASK[13:0], 2'b00};
  // bus and pins
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [15:0] paddr = 16'h0000;
  logic [31:0] pwdata = 32'h0000_0000;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic stop_mode = 1'b0;
  logic fll_locked_pin = 1'b0;
  logic ext_clock_pin;
  csc_ctrl_t ctrl;
  csc_osc_t osc;
  logic osc_run;
  logic ext_out;
  logic irq;
  // last read data and error, verdict counters
  logic [31:0] rd;
  logic err;
  int error_cnt = 0;
  int comparisons = 0;

  // 40 MHz clock
  always #12.5 pclk = ~pclk;

  csc_top dut_u (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .stop_mode(stop_mode), .fll_locked_pin(fll_locked_pin), .ext_clock_pin(ext_clock_pin),
    .ctrl(ctrl), .osc(osc), .osc_run(osc_run), .external_ref_clock_out(ext_out), .irq(irq)
  );

  csc_osc_model osc_u (.osc_run(osc_run), .ext_clock_pin(ext_clock_pin));

  // one comparison, four-state exact
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp)
    begin
      error_cnt++;
      $display("[ERR] %0t got %h exp %h", $time, got, exp);
    end
  endtask

  // one apb transfer, held until pready is seen high
  task automatic apb(input logic w, input logic [15:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  // read and compare
  task automatic rdchk(input logic [15:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0000_0000);
    chk(rd, exp);
  endtask

  // poll a field until it shows a value, bounded
  task automatic poll(input logic [15:0] a, input logic [31:0] m, input logic [31:0] v);
    int n;
    n = 0;
    do
    begin
      apb(1'b0, a, 32'h0000_0000);
      n++;
    end
    while ((rd & m) !== v && n < 3000);
  endtask

  // reset values, reserved bits, unmapped access
  task automatic t_reset();
    rdchk(A_ST, 32'h0000_0010);
    rdchk(A_OSC, 32'h0000_0000);
    rdchk(A_CT, 32'h0000_0001);
    chk(32'(ctrl), 32'h0000_0001);
    rdchk(A_ST + 16'h0004, 32'h0000_0000);
    chk(32'(err), 32'h0000_0001);
  endtask

  // lock, interrupt, stop, config change, sticky loss
  task automatic t_lock();
    fll_locked_pin <= 1'b1;
    poll(A_ST, 32'h0000_0040, 32'h0000_0040);
    chk(rd, 32'h0000_0050);
    rdchk(A_IS, 32'h0000_0002);
    apb(1'b1, A_IM, 32'h0000_0002);
    // mask lands at the access edge, irq follows it at once
    @(posedge pclk);
    chk(32'(irq), 32'h0000_0001);
    apb(1'b1, A_IS, 32'h0000_0002);
    @(posedge pclk);
    chk(32'(irq), 32'h0000_0000);
    apb(1'b1, A_IM, 32'h0000_0000);
    stop_mode <= 1'b1;
    rdchk(A_ST, 32'h0000_0010);
    stop_mode <= 1'b0;
    // acquire time after wake, lock flag not awaited first
    repeat (20) @(posedge pclk);
    poll(A_ST, 32'h0000_0040, 32'h0000_0040);
    chk(rd, 32'h0000_0050);
    apb(1'b1, A_CT, 32'h0000_0000);
    rdchk(A_ST, 32'h0000_0010);
    poll(A_ST, 32'h0000_0040, 32'h0000_0040);
    chk(rd, 32'h0000_0040);
    fll_locked_pin <= 1'b0;
    poll(A_ST, 32'h0000_0080, 32'h0000_0080);
    chk(rd, 32'h0000_0080);
    apb(1'b1, A_ST, 32'h0000_0000);
    rdchk(A_ST, 32'h0000_0080);
    apb(1'b1, A_ST, 32'h0000_0080);
    rdchk(A_ST, 32'h0000_0000);
    apb(1'b0, A_IS, 32'h0000_0000);
    chk(rd & 32'h0000_0003, 32'h0000_0003);
    apb(1'b1, A_IS, 32'h0000_0007);
  endtask

  // every clock mode code, status lags the select
  task automatic t_modes();
    logic [31:0] prev;
    // reference was external and mode zero when this starts
    prev = 32'h0000_0000;
    for (int m = 0; m < 3; m++)
    begin
      apb(1'b1, A_CT, 32'(m * 2 + 1));
      rdchk(A_ST, prev);
      chk(32'(ctrl), 32'(m * 2 + 1));
      prev = 32'h0000_0010 | 32'(m * 4);
      rdchk(A_ST, prev);
    end
    apb(1'b1, A_CT, 32'h0000_0001);
  endtask

  // oscillator controls, ready flag, stop keep
  task automatic t_osc();
    int hi;
    apb(1'b1, A_OSC, 32'h0000_00FF);
    rdchk(A_OSC, 32'h0000_00B6);
    chk(32'(osc), 32'h0000_001F);
    poll(A_OSC, 32'h0000_0001, 32'h0000_0001);
    chk(rd, 32'h0000_00B7);
    rdchk(A_IS, 32'h0000_0004);
    hi = 0;
    repeat (40) @(posedge pclk) hi += int'(ext_out === 1'b1);
    chk(32'(hi > 0 && hi < 40), 32'h0000_0001);
    stop_mode <= 1'b1;
    repeat (3) @(posedge pclk);
    chk(32'(osc_run), 32'h0000_0001);
    apb(1'b1, A_OSC, 32'h0000_0096);
    repeat (3) @(posedge pclk);
    chk(32'(osc_run), 32'h0000_0000);
    rdchk(A_OSC, 32'h0000_0096);
    stop_mode <= 1'b0;
    apb(1'b1, A_OSC, 32'h0000_0000);
    repeat (8) @(posedge pclk);
    chk(32'(ext_out), 32'h0000_0000);
    rdchk(A_OSC, 32'h0000_0000);
  endtask

  // verdict and end of run
  task automatic final_report();
    if (error_cnt == 0 && comparisons > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask

  // main sequence
  initial
  begin
    repeat (16) @(posedge pclk);
    presetn <= 1'b1;
    t_reset();
    t_lock();
    t_modes();
    t_osc();
    final_report();
  end

  // watchdog, well beyond the longest oscillator start
  initial
  begin
    repeat (60000) @(posedge pclk);
    error_cnt++;
    final_report();
  end
endmodule
